// [rtl/cmpevt_pkg.sv]
// package for the comparator event and status control block
// assumes an apb master with 32-bit data and four comparator front ends
// Function
// - idle-halt bit set stops all comparators in idle; clear keeps them running
// - status bits 11..8 mirror event flags of comparators 4..1
// - status bits 3..0 mirror outputs of comparators 4..1
// - output is 1 when plus exceeds minus, inverted when inversion set
// - unimplemented status and control bits read as zero
// - edge policy 11 fires on any output change
// - policy 10 fires on falling, 01 on rising adjusted output
// - policy 00 never fires
// - new events detected only while the event flag is clear
// - reference select 1 picks internal reference, 0 picks plus pin one
// - channel 00 picks minus pin one, 01 minus pin two, others none
// - a selected source absent on the package ties the input to ground
// - internal reference and minus pin two unavailable in amplifier mode
package cmpevt_pkg;
   localparam int unsigned num_cmp = 4;
   // register byte addresses
   localparam logic [11:0] addr_status = 12'h000;
   localparam logic [11:0] addr_ctrl_base = 12'h004;   // four words from here
   localparam logic [11:0] addr_irq_mask = 12'h014;
   localparam logic [11:0] addr_irq_stat = 12'h018;
   // status field positions
   localparam int unsigned pos_idle_halt = 15;
   localparam int unsigned pos_evt_mirror = 8;
   localparam int unsigned pos_out_mirror = 0;
   // control field positions
   localparam int unsigned pos_amp_mode = 10;
   localparam int unsigned pos_evt_flag = 9;
   localparam int unsigned pos_result = 8;
   localparam int unsigned pos_policy = 6;
   localparam int unsigned pos_inversion = 13;
   localparam int unsigned pos_pos_src = 4;
   localparam int unsigned pos_neg_ch = 0;
   // writable control bits
   localparam logic [15:0] ctrl_wr_mask = 16'h24d3;
   localparam logic [15:0] status_wr_mask = 16'h8000;
   // reset values
   localparam logic [15:0] ctrl_reset = 16'h0000;
   localparam logic [15:0] status_reset = 16'h0000;
   localparam logic [3:0] mask_reset = 4'h0;
   // edge policy codes
   localparam logic [1:0] pol_off = 2'b00;
   localparam logic [1:0] pol_rise = 2'b01;
   localparam logic [1:0] pol_fall = 2'b10;
   localparam logic [1:0] pol_any = 2'b11;
   // negative channel codes
   localparam logic [1:0] ch_neg_one = 2'b00;
   localparam logic [1:0] ch_neg_two = 2'b01;
endpackage

// [rtl/cmpevt_ch_if.sv]
// interface joining the top with one comparator channel
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface cmpevt_ch_if;
   logic [15:0] ctrl;      // channel control word
   logic        raw_out;   // raw comparator decision
   logic        halt;      // channel halted
   logic        clear_evt; // software cleared flag
   logic        evt_flag;  // sticky event flag
   logic        result;    // polarity adjusted result
   logic        trig;      // one-cycle trigger
   modport top (output ctrl, output raw_out, output halt, output clear_evt,
                input evt_flag, input result, input trig);
   modport ch (input ctrl, input raw_out, input halt, input clear_evt,
               output evt_flag, output result, output trig);
endinterface

// [rtl/cmpevt_channel.sv]
// one comparator channel: polarity, edge detection and sticky event flag
// assumes raw comparator decision already synchronous to mclk
`timescale 1ns/1ps
module cmpevt_channel
(
   input  wire logic  mclk, // system clock
   input  wire logic  rst,  // async reset, high
   cmpevt_ch_if.ch    chn   // channel link
);
   typedef struct packed
   {
      logic result;
      logic evt_flag;
      logic trig;
   } cmpevt_chst_t;
   cmpevt_chst_t st;
   cmpevt_chst_t next_st;
   logic         inv;
   logic         adj;
   logic [1:0]   pol;
   logic         fire;

   ////////////////////////////////////////////////////////////////////////
   // edge qualification against the previous adjusted result
   always_comb
   begin
      inv = chn.ctrl[cmpevt_pkg::pos_inversion];
      pol = chn.ctrl[cmpevt_pkg::pos_policy +: 2];
      adj = chn.raw_out ^ inv;
      next_st = st;
      next_st.trig = 1'b0;
      fire = 1'b0;
      if (!chn.halt)
      begin
         unique case (pol)
            cmpevt_pkg::pol_any: fire = adj != st.result;
            cmpevt_pkg::pol_fall: fire = st.result & ~adj;
            cmpevt_pkg::pol_rise: fire = ~st.result & adj;
            cmpevt_pkg::pol_off: fire = 1'b0;
         endcase
         fire = fire & ~st.evt_flag;
         next_st.result = adj;
      end
      // set beats a same-cycle software clear
      if (chn.clear_evt)
         next_st.evt_flag = 1'b0;
      if (fire)
      begin
         next_st.evt_flag = 1'b1;
         next_st.trig = 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         st <= '0;
      else
         st <= next_st;
   end

   assign chn.evt_flag = st.evt_flag;
   assign chn.result = st.result;
   assign chn.trig = st.trig;
endmodule

// [rtl/cmpevt_top.sv]
// top of the comparator event and status block, apb slave
// assumes analog comparators give a decision per channel from the routed sources
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module cmpevt_top
(
   input  wire logic        mclk,          // system clock 25 mhz
   input  wire logic        rst,           // async reset, high
   input  wire logic        psel,          // apb select
   input  wire logic        penable,       // apb enable
   input  wire logic        pwrite,        // apb direction
   input  wire logic [11:0] paddr,         // apb byte address
   input  wire logic [31:0] pwdata,        // apb write data
   output logic      [31:0] prdata,        // apb read data
   output logic             pready,        // apb ready
   output logic             pslverr,       // apb error
   input  wire logic        idle_mode,     // system is in idle
   input  wire logic [3:0]  cmp_raw,       // raw comparator decisions
   input  wire logic [3:0]  pkg_has_plus1, // plus pin one bonded
   input  wire logic [3:0]  pkg_has_minus1,// minus pin one bonded
   input  wire logic [3:0]  pkg_has_minus2,// minus pin two bonded
   output logic      [3:0]  sel_vref,      // plus input on internal reference
   output logic      [3:0]  sel_plus1,     // plus input on pin one
   output logic      [3:0]  sel_minus1,    // minus input on pin one
   output logic      [3:0]  sel_minus2,    // minus input on pin two
   output logic      [3:0]  cmp_enable,    // comparator running
   output logic      [3:0]  cmp_trigger,   // one-cycle event triggers
   output logic             irq            // level interrupt
);
   typedef struct packed
   {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        idle_halt;
      logic [3:0][15:0] ctrl;
      logic [3:0]  irq_mask;
      logic [3:0]  irq_stat;
      logic [3:0]  sel_vref;
      logic [3:0]  sel_plus1;
      logic [3:0]  sel_minus1;
      logic [3:0]  sel_minus2;
      logic [3:0]  cmp_enable;
      logic [3:0]  trig;
      logic        irq;
   } cmpevt_st_t;
   cmpevt_st_t  st;
   cmpevt_st_t  next_st;
   logic [3:0]  halt;
   logic [3:0]  clear_evt;
   logic [3:0]  evt_flag;
   logic [3:0]  result;
   logic [3:0]  trig;
   logic [15:0] status_word;
   logic        setup;
   logic [3:0]  next_stat;
   logic [15:0] ctrl_rd;
   logic [1:0]  ch;
   logic        amp;

   ////////////////////////////////////////////////////////////////////////
   // channel instances
   for (genvar i = 0; i < 4; i++)
   begin : g_ch
      cmpevt_ch_if link ();
      assign link.ctrl = st.ctrl[i];
      assign link.raw_out = cmp_raw[i];
      assign link.halt = halt[i];
      assign link.clear_evt = clear_evt[i];
      assign evt_flag[i] = link.evt_flag;
      assign result[i] = link.result;
      assign trig[i] = link.trig;
      cmpevt_channel u_ch
      (
         .mclk (mclk),
         .rst  (rst),
         .chn  (link)
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // shared status word and halt in idle
   always_comb
   begin
      status_word = cmpevt_pkg::status_reset;
      status_word[cmpevt_pkg::pos_idle_halt] = st.idle_halt;
      status_word[cmpevt_pkg::pos_evt_mirror +: 4] = evt_flag;
      status_word[cmpevt_pkg::pos_out_mirror +: 4] = result;
      halt = {4{st.idle_halt & idle_mode}};
   end

   ////////////////////////////////////////////////////////////////////////
   // apb access, no wait state; pready comes from a flop set in the setup cycle
   always_comb
   begin
      next_st = st;
      setup = psel & ~penable;
      clear_evt = 4'h0;
      ctrl_rd = 16'h0000;
      next_st.pready = setup;
      next_st.pslverr = 1'b0;
      next_st.prdata = 32'h0000_0000;
      next_stat = st.irq_stat;
      if (setup)
      begin
         if (paddr == cmpevt_pkg::addr_status)
         begin
            if (pwrite)
               next_st.idle_halt = pwdata[cmpevt_pkg::pos_idle_halt];
            next_st.prdata = {16'h0000, status_word};
         end
         else if (paddr >= cmpevt_pkg::addr_ctrl_base &&
                  paddr < cmpevt_pkg::addr_irq_mask && paddr[1:0] == 2'b00)
         begin
            ch = 2'(paddr[11:2] - 10'h001);
            ctrl_rd = st.ctrl[ch] & cmpevt_pkg::ctrl_wr_mask;
            ctrl_rd[cmpevt_pkg::pos_evt_flag] = evt_flag[ch];
            ctrl_rd[cmpevt_pkg::pos_result] = result[ch];
            next_st.prdata = {16'h0000, ctrl_rd};
            if (pwrite)
            begin
               next_st.ctrl[ch] = pwdata[15:0] & cmpevt_pkg::ctrl_wr_mask;
               // writing zero to the flag clears it
               clear_evt[ch] = ~pwdata[cmpevt_pkg::pos_evt_flag];
            end
         end
         else if (paddr == cmpevt_pkg::addr_irq_mask)
         begin
            if (pwrite)
               next_st.irq_mask = pwdata[3:0];
            next_st.prdata = {28'h0000000, st.irq_mask};
         end
         else if (paddr == cmpevt_pkg::addr_irq_stat)
         begin
            next_st.prdata = {28'h0000000, st.irq_stat};
            if (!pwrite)
               next_stat = 4'h0; // read clears
         end
         else
            next_st.pslverr = 1'b1;
      end
      // new events win over the read clear
      next_st.irq_stat = next_stat | trig;
      next_st.trig = trig;
      next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
      // input routing with ground when absent or blocked
      for (int i = 0; i < 4; i++)
      begin
         amp = next_st.ctrl[i][cmpevt_pkg::pos_amp_mode];
         ch = next_st.ctrl[i][cmpevt_pkg::pos_neg_ch +: 2];
         next_st.sel_vref[i] = next_st.ctrl[i][cmpevt_pkg::pos_pos_src] & ~amp;
         next_st.sel_plus1[i] = ~next_st.ctrl[i][cmpevt_pkg::pos_pos_src]
                                & pkg_has_plus1[i];
         next_st.sel_minus1[i] = (ch == cmpevt_pkg::ch_neg_one) & pkg_has_minus1[i];
         next_st.sel_minus2[i] = (ch == cmpevt_pkg::ch_neg_two) & ~amp
                                 & pkg_has_minus2[i];
         next_st.cmp_enable[i] = ~halt[i];
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         st <= '0;
      else
         st <= next_st;
   end

   // outputs straight from flops
   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign sel_vref = st.sel_vref;
   assign sel_plus1 = st.sel_plus1;
   assign sel_minus1 = st.sel_minus1;
   assign sel_minus2 = st.sel_minus2;
   assign cmp_enable = st.cmp_enable;
   assign cmp_trigger = st.trig;
   assign irq = st.irq;
endmodule

// [bench/cmpevt_front_model.sv]
// behavioural analog front ends for the four comparators
// assumes one shared level per pin, in millivolts, seen by every channel
`timescale 1ns/1ps
module cmpevt_front_model
(
   input wire logic       mclk,       // clock
   input wire logic [3:0] sel_vref,   // plus on reference
   input wire logic [3:0] sel_plus1,  // plus on pin one
   input wire logic [3:0] sel_minus1, // minus on pin one
   input wire logic [3:0] sel_minus2, // minus on pin two
   input wire logic [3:0] cmp_enable, // running
   input int              vp1,        // plus pin one level
   input int              vm1,        // minus pin one level
   output logic [3:0]     cmp_raw     // decisions, synchronous
);
   int vp;
   int vm;
   initial cmp_raw = 4'h0;
   ////////////////////
   // an unrouted input sits at ground; a halted comparator holds its output
   always @(posedge mclk)
   begin
      for (int i = 0; i < 4; i++)
      begin
         vp = sel_vref[i] ? 400 : (sel_plus1[i] ? vp1 : 0);
         vm = sel_minus1[i] ? vm1 : (sel_minus2[i] ? 100 : 0);
         if (cmp_enable[i])
            cmp_raw[i] <= vp > vm;
      end
   end
endmodule

// [bench/cmpevt_top_monitor.sv]
// port checker for the comparator event block
// assumes one clock and the apb timing of the top
`timescale 1ns/1ps
module cmpevt_top_monitor
(
   input wire logic        mclk,           // clock
   input wire logic        rst,            // reset
   input wire logic        psel,           // apb
   input wire logic        penable,        // apb
   input wire logic        pwrite,         // apb
   input wire logic [11:0] paddr,          // apb
   input wire logic [31:0] pwdata,         // apb
   input wire logic [31:0] prdata,         // apb
   input wire logic        pready,         // apb
   input wire logic        idle_mode,      // idle
   input wire logic [3:0]  pkg_has_minus1, // bonded
   input wire logic [3:0]  sel_minus1,     // route
   input wire logic [3:0]  sel_minus2,     // route
   input wire logic [3:0]  cmp_enable,     // running
   input wire logic [3:0]  cmp_trigger,    // events
   input wire logic        irq             // interrupt
);
   logic [3:0] msk;
   logic       halt;
   wire        rdok = pready && !pwrite;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   ////////////////////
   // shadows taken at the setup edge, where the design takes writes
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         msk  <= 4'h0;
         halt <= 1'b0;
      end
      else if (psel && !penable && pwrite && paddr == cmpevt_pkg::addr_status)
         halt <= pwdata[15];
      else if (psel && !penable && pwrite && paddr == cmpevt_pkg::addr_irq_mask)
         msk <= pwdata[3:0];
   end
   a_idle_stops: assert property ((idle_mode && halt) [*3] |-> cmp_enable == 4'h0)
      else $error("comparator running while halted in idle");
   a_awake_runs: assert property ((!(idle_mode && halt)) [*3] |-> cmp_enable == 4'hf)
      else $error("comparator stopped while allowed to run");
   a_status_holes: assert property (rdok && paddr == 12'h000 |-> (prdata & 32'hffff70f0) == 0)
      else $error("status hole reads nonzero");
   a_ctrl_holes: assert property (rdok && paddr inside {12'h004, 12'h008, 12'h00c, 12'h010}
      |-> (prdata & 32'hffff002c) == 0) else $error("control hole reads nonzero");
   a_one_shot: assert property (cmp_trigger != 4'h0 |=> (cmp_trigger & $past(cmp_trigger)) == 0)
      else $error("trigger repeated while flag set");
   a_minus_single: assert property ((sel_minus1 & sel_minus2) == 4'h0)
      else $error("two minus sources routed");
   a_absent_ground: assert property ((sel_minus1 & ~pkg_has_minus1 & ~$past(pkg_has_minus1)) == 0)
      else $error("absent pin routed");
   a_irq_level: assert property ((cmp_trigger & msk) != 4'h0 |-> irq)
      else $error("unmasked event without interrupt");
   c_event: cover property (cmp_trigger[0]);
   c_halted: cover property (idle_mode && halt && cmp_enable == 4'h0);
   c_irq: cover property (irq);
endmodule
bind cmpevt_top cmpevt_top_monitor u_mon (.*);

// [bench/cmpevt_top_bench.sv]
// self-checking bench for the comparator event block
// assumes the front-end model drives the raw decisions
`timescale 1ns/1ps
module cmpevt_top_bench;
   localparam logic [11:0] st = cmpevt_pkg::addr_status;
   localparam logic [11:0] c1 = cmpevt_pkg::addr_ctrl_base;
   localparam logic [11:0] im = cmpevt_pkg::addr_irq_mask;
   localparam logic [11:0] is = cmpevt_pkg::addr_irq_stat;
   logic        mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        idle_mode = 1'b0, pready, pslverr, irq, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0]  cmp_raw, pkg_has_plus1 = 4'hf, pkg_has_minus1 = 4'hf, pkg_has_minus2 = 4'hf;
   logic [3:0]  sel_vref, sel_plus1, sel_minus1, sel_minus2, cmp_enable, cmp_trigger;
   int          vp1 = 200, vm1 = 300, failures = 0, checks_done = 0, ntrig = 0;
   cmpevt_top u_dut (.*);
   cmpevt_front_model u_front (.*);
   always #20 mclk = ~mclk;
   // channel one trigger pulses
   always @(posedge mclk)
      if (cmp_trigger[0] === 1'b1)
         ntrig <= ntrig + 1;
   ////////////////////
   // one apb transfer; held until pready, then released for an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1)
         @(posedge mclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic hold(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic final_report;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // every edge policy under both polarities, channel one only
   task automatic t_edges;
      logic [31:0] c;
      logic        up, dn;
      apb(1'b1, im, 32'h1);
      for (int k = 0; k < 8; k++)
      begin
         c = (32'(k[2]) << 13) | (32'(k[1:0]) << 6);
         up = k[1:0] == 2'b11 || k[1:0] == {k[2], ~k[2]};
         dn = k[1:0] == 2'b11 || k[1:0] == {~k[2], k[2]};
         vp1 <= 200;
         apb(1'b1, c1, c);
         hold(6);
         apb(1'b1, c1, c);
         apb(1'b0, is, 0);
         vp1 <= 500;
         hold(6);
         chk("irq", irq, up);
         apb(1'b0, st, 0);
         chk("status", rd[11:0], {3'b000, up, 4'h0, 3'b111, ~k[2]});
         apb(1'b0, is, 0);
         hold(2);
         chk("irq clear", irq, 0);
         apb(1'b1, c1, c);
         vp1 <= 200;
         hold(6);
         apb(1'b0, st, 0);
         chk("fall", rd[11:8], {3'b000, dn});
      end
   endtask
   // flag left set: later changes stay silent; mask holds irq low
   task automatic t_sticky;
      int n0;
      apb(1'b1, im, 0);
      apb(1'b1, c1, 32'h00c0);
      hold(6);
      apb(1'b1, c1, 32'h00c0);
      n0 = ntrig;
      for (int j = 0; j < 3; j++)
      begin
         vp1 <= (j % 2 == 0) ? 500 : 200;
         hold(6);
      end
      chk("one trigger", ntrig - n0, 1);
      chk("masked irq", irq, 0);
   endtask
   task automatic t_idle;
      idle_mode <= 1'b1;
      hold(3);
      chk("idle run", cmp_enable, 4'hf);
      apb(1'b1, st, 32'h8000);
      hold(3);
      chk("idle stop", cmp_enable, 4'h0);
      apb(1'b1, st, 0);
      idle_mode <= 1'b0;
      hold(3);
   endtask
   task automatic t_regs;
      apb(1'b1, c1 + 12'h4, 32'hffffffed);
      apb(1'b0, c1 + 12'h4, 0);
      chk("ctrl holes", rd & 32'hffff002c, 0);
      apb(1'b0, st, 0);
      chk("status holes", rd & 32'hffff70f0, 0);
      apb(1'b0, 12'h01c, 0);
      chk("unmapped", {er, rd[30:0]}, 32'h80000000);
      apb(1'b1, c1 + 12'h4, 0);
      vp1 <= 200;
      pkg_has_minus1 <= 4'he;
      hold(6);
      apb(1'b0, st, 0);
      chk("ground", rd[3:0], 4'h1);
   endtask
   // input routing of channel one; amplifier mode blocks reference and pin two
   task automatic t_route;
      apb(1'b1, c1, 32'h0010);
      chk("vref", {sel_vref[0], sel_plus1[0]}, 2'b10);
      apb(1'b1, c1, 32'h0001);
      chk("minus two", {sel_minus2[0], sel_minus1[0], sel_plus1[0]}, 3'b101);
      apb(1'b1, c1, 32'h0411);
      chk("amp blocks", {sel_vref[0], sel_minus2[0]}, 2'b00);
      apb(1'b1, c1, 32'h0002);
      chk("channel 10", {sel_minus2[0], sel_minus1[0]}, 2'b00);
   endtask
   // main sequence
   initial
   begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      t_edges;
      t_sticky;
      t_idle;
      t_regs;
      t_route;
      final_report;
   end
   // hang guard, 5000 cycles, far beyond the few hundred cycles needed
   initial
   begin
      #200us;
      failures++;
      final_report;
   end
endmodule
